// *** asram_ctrl.sv ***
// Host-side controller for an asynchronous 512K x 16 SRAM with two selects and two lanes.
// Assumes synchronous user requests and a memory wired to the pin outputs; the testbench
// resolves the shared data lines from data_oe_o and the memory's own drive.
//
// What this block does
// - Controller never drives data lines while the memory may drive them.
// - Address stable at least write setup time before write strobe rises.
// - Selects and chosen lanes active at least write setup time before write end.
// - In lane-controlled retention, selects are held at full steady rail levels.
// - In select-one retention, select two is held steady at a rail.
// - Deselect is established no later than supply drop, margin zero.
// - After supply returns, wait five ms before deselect release and accesses.
// - Address presented in the same edge the write strobe falls and held unchanged until it ends.
`timescale 1ns/1ps
module asram_ctrl
    import asram_pkg::*;
#(
    parameter int EXIT_CYCLES = EXIT_CYC
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    // User request
    input  wire logic              req_valid_i,
    input  wire logic              req_write_i,
    input  wire logic [ADDR_W-1:0] req_addr_i,
    input  wire logic [DATA_W-1:0] req_wdata_i,
    input  wire logic [1:0]        req_lanes_i,
    output logic                   req_ready_o,
    // Read answer
    output logic                   rsp_valid_o,
    output logic [DATA_W-1:0]      rsp_rdata_o,
    // Retention control
    input  wire logic              retain_req_i,
    output logic                   retain_safe_o,
    output logic                   retain_busy_o,
    // Memory pins
    output asram_pins_s            pins_o,
    output logic [DATA_W-1:0]      data_o,
    output logic                   data_oe_o,
    input  wire logic [DATA_W-1:0] data_i
);

    // ****************************************
    // State and timer
    // ****************************************
    asram_state_e state;
    asram_state_e next_state;
    logic         tmr_load;
    logic [CNT_W-1:0] tmr_value;
    logic         tmr_done;
    logic [1:0]   lanes;

    asram_timer #(.W(CNT_W)) u_timer (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .load_i  (tmr_load),
        .value_i (tmr_value),
        .done_o  (tmr_done)
    );

    // Lane-mask decode, used for both pins and read-data merge
    function automatic logic lane_on(input logic [1:0] m, input int i);
        return m[i];
    endfunction

    assign req_ready_o   = (state == ST_IDLE) && !retain_req_i;
    assign retain_busy_o = (state == ST_RETIN) || (state == ST_RET) || (state == ST_RECOV);

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_state = state;
        tmr_load   = 1'b0;
        tmr_value  = '0;
        case (state)
            ST_IDLE: begin
                if (retain_req_i) begin
                    next_state = ST_RETIN;
                    tmr_load   = 1'b1;
                    tmr_value  = CNT_W'(ENTRY_CYC);
                end else if (req_valid_i && req_lanes_i != 2'b00) begin
                    tmr_load = 1'b1;
                    if (req_write_i) begin
                        next_state = ST_WR;
                        tmr_value  = CNT_W'(WSETUP_CYC);
                    end else begin
                        next_state = ST_RD;
                        tmr_value  = CNT_W'(ACC_CYC);
                    end
                end
            end
            ST_RD: begin
                if (tmr_done) begin
                    next_state = ST_TURN;
                    tmr_load   = 1'b1;
                    tmr_value  = CNT_W'(DIS_CYC);
                end
            end
            ST_WR: begin
                if (tmr_done) begin
                    next_state = ST_WREND;
                end
            end
            ST_WREND: begin
                next_state = ST_IDLE;
            end
            ST_TURN: begin
                if (tmr_done) begin
                    next_state = ST_IDLE;
                end
            end
            ST_RETIN: begin
                if (tmr_done) begin
                    next_state = ST_RET;
                end
            end
            ST_RET: begin
                if (!retain_req_i) begin
                    next_state = ST_RECOV;
                    tmr_load   = 1'b1;
                    tmr_value  = CNT_W'(EXIT_CYCLES);
                end
            end
            ST_RECOV: begin
                if (tmr_done) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************
    // Pin drive
    // ****************************************
    // Address, selects and lanes are set in the same edge the access starts and held
    // until it ends; the write strobe falls together with them, never before.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pins_o <= PINS_IDLE;
            lanes  <= 2'b00;
        end else if (state == ST_IDLE && next_state inside {ST_RD, ST_WR}) begin
            pins_o.addr                <= req_addr_i;
            pins_o.select_one_n        <= 1'b0;
            pins_o.select_two          <= 1'b1;
            pins_o.lower_lane_enable_n <= !lane_on(req_lanes_i, 0);
            pins_o.upper_lane_enable_n <= !lane_on(req_lanes_i, 1);
            pins_o.write_n             <= !req_write_i;
            pins_o.output_enable_n     <= req_write_i;
            lanes                      <= req_lanes_i;
        end else if (next_state == ST_WREND || next_state == ST_TURN) begin
            // Write strobe rises while address and selects still stand
            pins_o.write_n             <= 1'b1;
            pins_o.output_enable_n     <= 1'b1;
        end else if (state == ST_WREND || next_state == ST_IDLE || next_state == ST_RETIN) begin
            // Full deselect; select two low is a steady rail level for retention
            pins_o.select_one_n        <= 1'b1;
            pins_o.select_two          <= 1'b0;
            pins_o.lower_lane_enable_n <= 1'b1;
            pins_o.upper_lane_enable_n <= 1'b1;
            pins_o.write_n             <= 1'b1;
            pins_o.output_enable_n     <= 1'b1;
        end
    end

    // ****************************************
    // Data lines
    // ****************************************
    // Drive from the write strobe fall until the deselect edge one cycle after it rises; the read
    // turn-around waits out the memory's disable time before any later write can drive.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            data_o    <= '0;
            data_oe_o <= 1'b0;
        end else if (state == ST_IDLE && next_state == ST_WR) begin
            data_o    <= req_wdata_i;
            data_oe_o <= 1'b1;
        end else if (state == ST_WREND) begin
            data_oe_o <= 1'b0;
        end
    end

    // ****************************************
    // Read capture
    // ****************************************
    // Sampled only after the worst-case access time; unselected lanes read as zero.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rsp_valid_o <= 1'b0;
            rsp_rdata_o <= '0;
        end else begin
            rsp_valid_o <= (state == ST_RD) && tmr_done;
            if ((state == ST_RD) && tmr_done) begin
                for (int i = 0; i < 2; i++) begin
                    rsp_rdata_o[i*LANE_W +: LANE_W] <= lane_on(lanes, i) ?
                                                      data_i[i*LANE_W +: LANE_W] : '0;
                end
            end
        end
    end

    // Supply may drop once the deselect has settled
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            retain_safe_o <= 1'b0;
        end else begin
            retain_safe_o <= (state == ST_RET);
        end
    end

endmodule

// *** asram_pkg.sv ***
// Package for the asynchronous SRAM host controller: timing, pin bundles, states.
// Assumes a single 250 MHz clock; all pin timing is counted in whole cycles.
package asram_pkg;

    // ****************************************
    // Clock and geometry
    // ****************************************
    localparam int CLK_PERIOD_PS = 4000;
    localparam int ADDR_W        = 19;
    localparam int DATA_W        = 16;
    localparam int LANE_W        = 8;

    // ****************************************
    // Timing figures in ns (faster grade defaults) and ms
    // ****************************************
    localparam int T_ACC_NS      = 70;   // Access from address/select/lane
    localparam int T_OE_ACC_NS   = 35;   // Access from output enable
    localparam int T_DIS_NS      = 25;   // Output release after deassert
    localparam int T_WSETUP_NS   = 65;   // Address/select setup to write end
    localparam int T_DSETUP_NS   = 35;   // Data setup to write end
    localparam int T_ENTRY_NS    = 0;    // Retention entry margin
    localparam int T_EXIT_MS     = 5;    // Retention exit wait

    // Least times round up to whole cycles, never below one
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int ACC_CYC    = ns_to_cyc(T_ACC_NS);
    localparam int OE_CYC     = ns_to_cyc(T_OE_ACC_NS);
    localparam int DIS_CYC    = ns_to_cyc(T_DIS_NS);
    localparam int WSETUP_CYC = ns_to_cyc(T_WSETUP_NS);
    localparam int DSETUP_CYC = ns_to_cyc(T_DSETUP_NS);
    localparam int ENTRY_CYC  = ns_to_cyc(T_ENTRY_NS);
    localparam int EXIT_CYC   = T_EXIT_MS * 1000000 / (CLK_PERIOD_PS / 1000);
    localparam int CNT_W      = 24;

    // ****************************************
    // Pin bundle towards the memory
    // ****************************************
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              select_one_n;
        logic              select_two;
        logic              lower_lane_enable_n;
        logic              upper_lane_enable_n;
        logic              write_n;
        logic              output_enable_n;
    } asram_pins_s;

    localparam asram_pins_s PINS_IDLE = '{addr: '0, select_one_n: 1'b1, select_two: 1'b0,
                                          lower_lane_enable_n: 1'b1, upper_lane_enable_n: 1'b1,
                                          write_n: 1'b1, output_enable_n: 1'b1};

    typedef enum logic [7:0] {
        ST_IDLE   = 8'h01,
        ST_RD     = 8'h02,
        ST_WR     = 8'h04,
        ST_WREND  = 8'h08,
        ST_TURN   = 8'h10,
        ST_RETIN  = 8'h20,
        ST_RET    = 8'h40,
        ST_RECOV  = 8'h80
    } asram_state_e;

endpackage

// *** asram_timer.sv ***
// Down-counter used for every pin-timing interval of the controller except the one-cycle write end in ST_WREND.
// Assumes load and count come from one clock domain.
`timescale 1ns/1ps
module asram_timer
    import asram_pkg::*;
#(
    parameter int W = CNT_W
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // Control
    input  wire logic         load_i,
    input  wire logic [W-1:0] value_i,
    // Status
    output logic              done_o
);
    logic [W-1:0] count;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            count <= '0;
        end else if (load_i) begin
            count <= value_i;
        end else if (count != '0) begin
            count <= count - W'(1);
        end
    end

    // Done in the cycle the count reaches zero and while it stays there; it does not
    // look at load_i, since the controller reloads on done and that would form a loop
    assign done_o = (count == '0);
endmodule

// *** asram_monitor.sv ***
// Checker for the SRAM host controller: pin timing seen at its ports.
// Assumes it is bound to asram_ctrl and sees only that module's ports.
`timescale 1ns/1ps
module asram_monitor
    import asram_pkg::*;
#(
    parameter int EXIT_CYCLES = EXIT_CYC
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // Watched ports
    input  wire logic        req_ready_o,
    input  wire logic        rsp_valid_o,
    input  wire logic        retain_req_i,
    input  wire logic        retain_safe_o,
    input  wire asram_pins_s pins_o,
    input  wire logic        data_oe_o
);
    // ****************************************
    // Interval counters
    // ****************************************
    localparam int WR_MIN = WSETUP_CYC - 1;
    logic [7:0] wr_cnt;
    logic [7:0] sel_cnt;
    logic       active;

    assign active = !pins_o.select_one_n && pins_o.select_two
                    && !(pins_o.lower_lane_enable_n && pins_o.upper_lane_enable_n);

    // The first low cycle after an address change is not counted, hence WR_MIN
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || pins_o.write_n || $changed(pins_o.addr))
            wr_cnt <= 8'h00;
        else if (wr_cnt != 8'hFF)
            wr_cnt <= wr_cnt + 8'h01;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !active)
            sel_cnt <= 8'h00;
        else if (sel_cnt != 8'hFF)
            sel_cnt <= sel_cnt + 8'h01;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_no_contention: assert property (data_oe_o |-> pins_o.output_enable_n)
        else $error("controller drives data while output enable is low");
    a_write_gated: assert property (!pins_o.write_n |-> active)
        else $error("write strobe low without selects and a lane");
    a_addr_setup: assert property ($rose(pins_o.write_n) |-> wr_cnt >= WR_MIN)
        else $error("address not stable long enough before write end");
    a_select_setup: assert property ($rose(pins_o.write_n) |-> sel_cnt >= WSETUP_CYC)
        else $error("selects and lanes not active long enough before write end");
    a_addr_held: assert property (!pins_o.write_n |=> $stable(pins_o.addr))
        else $error("address moved during a write");
    a_read_late: assert property (rsp_valid_o |-> sel_cnt >= ACC_CYC)
        else $error("read data taken before the access time");
    a_turnaround: assert property ($rose(pins_o.output_enable_n) |-> !data_oe_o [*7])
        else $error("data driven before the memory released the lines");
    a_retain_off: assert property (retain_safe_o |-> pins_o.select_one_n && !pins_o.select_two)
        else $error("retention signalled while selected");
    a_exit_wait: assert property ($fell(retain_req_i) |-> !req_ready_o [*8])
        else $error("accesses accepted too soon after retention");
    a_idle_quiet: assert property (req_ready_o |-> pins_o.select_one_n && !data_oe_o)
        else $error("idle controller still selects or drives");
endmodule

// *** asram_mem_model.sv ***
// Behavioural model of the asynchronous 512K x 16 memory on the controller's pins.
// Assumes the testbench resolves the shared data lines and feeds them to data_i.
`timescale 1ns/1ps
module asram_mem_model
    import asram_pkg::*;
(
    // Pins from the controller
    input  wire asram_pins_s       pins_i,
    // Shared data lines
    input  wire logic [DATA_W-1:0] data_i,
    output logic [DATA_W-1:0]      data_o
);
    int                acc_ns = 68;
    logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
    realtime           t_chg = 0;
    logic              sel;
    logic [DATA_W-1:0] mask;

    assign sel  = !pins_i.select_one_n && pins_i.select_two;
    assign mask = {{LANE_W{!pins_i.upper_lane_enable_n}}, {LANE_W{!pins_i.lower_lane_enable_n}}};

    function automatic logic [DATA_W-1:0] rd_word();
        return mem.exists(pins_i.addr) ? mem[pins_i.addr] : '0;
    endfunction

    initial data_o = '0;

    // Any pin change restarts the access; old data is not held past it
    always @(pins_i) t_chg = $realtime;

    // ****************************************
    // Write at strobe rise, read after full access
    // ****************************************
    always @(posedge pins_i.write_n) begin
        if (sel && mask != '0)
            mem[pins_i.addr] = (rd_word() & ~mask) | (data_i & mask);
    end

    // Undriven lanes toggle so stale values never pass
    always #1 begin
        if (sel && pins_i.write_n && !pins_i.output_enable_n && $realtime - t_chg >= acc_ns)
            data_o = (rd_word() & mask) | (~data_o & ~mask);
        else
            data_o = ~data_o;
    end
endmodule

// *** test_asram_ctrl.sv ***
// Self-checking testbench for the SRAM host controller.
// Assumes the memory model stands on the pins and the checker is bound below.
`timescale 1ns/1ps
module test_asram_ctrl import asram_pkg::*; ();
    localparam int EXIT_SIM = 20;
    logic              clk_i = 1'b0;
    logic              rst_n_i = 1'b0;
    logic              req_valid_i = 1'b0;
    logic              req_write_i = 1'b0;
    logic              retain_req_i = 1'b0;
    logic [ADDR_W-1:0] req_addr_i = '0;
    logic [DATA_W-1:0] req_wdata_i = '0;
    logic [1:0]        req_lanes_i = 2'h0;
    logic              req_ready_o;
    logic              rsp_valid_o;
    logic              retain_safe_o;
    logic              retain_busy_o;
    logic              data_oe_o;
    logic [DATA_W-1:0] rsp_rdata_o;
    logic [DATA_W-1:0] data_o;
    logic [DATA_W-1:0] mem_q;
    logic [DATA_W-1:0] bus;
    asram_pins_s       pins_o;
    int                n_mismatch = 0;
    int                cmp_count = 0;

    always #2 clk_i = ~clk_i;
    assign bus = data_oe_o ? data_o : mem_q;

    asram_ctrl #(.EXIT_CYCLES(EXIT_SIM)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i),
        .req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .req_lanes_i(req_lanes_i),
        .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o), .retain_req_i(retain_req_i),
        .retain_safe_o(retain_safe_o), .retain_busy_o(retain_busy_o), .pins_o(pins_o), .data_o(data_o),
        .data_oe_o(data_oe_o),
        .data_i(bus));
    asram_mem_model u_mem (.pins_i(pins_o), .data_i(bus), .data_o(mem_q));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic wait_ready(input int lim, output int i);
        for (i = 0; i < lim && req_ready_o !== 1'b1; i++) tick(1);
        if (i == lim) begin
            n_mismatch++;
            wrap_up();
        end
    endtask

    task automatic issue(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                         input logic [1:0] ln);
        int i;
        wait_ready(200, i);
        req_valid_i = 1'b1;
        req_write_i = wr;
        req_addr_i = a;
        req_wdata_i = d;
        req_lanes_i = ln;
        tick(1);
        req_valid_i = 1'b0;
    endtask

    task automatic read_chk(input logic [ADDR_W-1:0] a, input logic [1:0] ln, input logic [DATA_W-1:0] exp);
        int i;
        issue(1'b0, a, '0, ln);
        for (i = 0; i < 40 && rsp_valid_o !== 1'b1; i++) tick(1);
        check(i, ACC_CYC + 1);
        if (i == 40)
            wrap_up();
        check(rsp_rdata_o, exp);
        tick(1);
        check(rsp_valid_o, 1'b0);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic s_write_read();
        issue(1'b1, 19'h7FFFF, 16'hA5C3, 2'h3);
        issue(1'b1, 19'h00000, 16'h3C5A, 2'h3);
        read_chk(19'h7FFFF, 2'h3, 16'hA5C3);
        read_chk(19'h00000, 2'h3, 16'h3C5A);
    endtask

    task automatic s_lanes();
        issue(1'b1, 19'h7FFFF, 16'h115A, 2'h1);
        issue(1'b1, 19'h00000, 16'hE722, 2'h2);
        read_chk(19'h7FFFF, 2'h3, 16'hA55A);
        read_chk(19'h00000, 2'h2, 16'hE700);
        u_mem.acc_ns = 6;
        read_chk(19'h00000, 2'h1, 16'h005A);
        u_mem.acc_ns = 68;
    endtask

    task automatic s_no_lanes();
        issue(1'b1, 19'h00000, 16'hFFFF, 2'h0);
        check(req_ready_o, 1'b1);
        check(pins_o.select_one_n, 1'b1);
        read_chk(19'h00000, 2'h3, 16'hE75A);
    endtask

    task automatic s_retention();
        int i;
        retain_req_i = 1'b1;
        for (i = 0; i < 50 && retain_safe_o !== 1'b1; i++) tick(1);
        check(retain_safe_o, 1'b1);
        if (i == 50)
            wrap_up();
        check(retain_busy_o, 1'b1);
        check({pins_o.select_one_n, pins_o.select_two}, 2'h2);
        req_valid_i = 1'b1;
        req_lanes_i = 2'h3;
        tick(5);
        check(req_ready_o, 1'b0);
        req_valid_i = 1'b0;
        retain_req_i = 1'b0;
        wait_ready(200, i);
        check(i >= EXIT_SIM, 1'b1);
        check(retain_busy_o, 1'b0);
        read_chk(19'h7FFFF, 2'h3, 16'hA55A);
    endtask

    initial begin
        tick(4);
        rst_n_i = 1'b1;
        s_write_read();
        s_lanes();
        s_no_lanes();
        s_retention();
        tick(10);
        wrap_up();
    end
endmodule

bind asram_ctrl asram_monitor #(.EXIT_CYCLES(EXIT_CYCLES)) u_mon (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .retain_req_i(retain_req_i),
    .retain_safe_o(retain_safe_o), .pins_o(pins_o), .data_oe_o(data_oe_o));
